// [design/card_socket_control.sv]
// control-signal logic for two removable-card sockets
`timescale 1ns/1ps
module card_socket_control (
  input  wire logic       mclk,             // 25 MHz core clock
  input  wire logic       rstn,             // async reset, active low
  input  wire logic [1:0] battery_sense_one, // sense one per socket
  input  wire logic [1:0] battery_sense_two, // sense two / audio / dreq
  input  wire logic [1:0] card_present_one, // detect one, low=inserted
  input  wire logic [1:0] card_present_two, // detect two, low=inserted
  input  wire logic [1:0] io_read_acknowledge, // ack, low active
  input  wire logic [1:0] ioMode,           // socket in I/O config
  input  wire logic [1:0] dmaMode,          // socket doing DMA
  input  wire logic [1:0] statusChangeEn,   // change interrupt enable
  input  wire logic [1:0] statusChangeClr,  // clear change flag, pulse
  input  wire logic       reqValid,         // start a card cycle
  input  wire card_socket_pkg::cycle_kind_t reqKind, // cycle kind
  input  wire logic       reqSocket,        // target socket
  input  wire logic [1:0] reqLanes,         // bit0 even, bit1 odd
  output logic            reqBusy,          // cycle in progress
  output logic            reqDone,          // cycle finished, pulse
  output logic            readAckSeen,      // card acked last I/O read
  output logic [1:0]      even_byte_select_n, // even enable, low
  output logic [1:0]      odd_byte_select_n,  // odd enable, low
  output logic [1:0]      io_read_strobe_n,   // read strobe, low
  output logic [1:0]      io_write_strobe_n,  // write strobe, low
  output logic [1:0]      dma_acknowledge_n,  // attribute/dma_acknowledge, low
  output card_socket_pkg::batt_state_t battStateA, // socket 0 battery
  output card_socket_pkg::batt_state_t battStateB, // socket 1 battery
  output logic [1:0]      cardInserted,     // socket holds a card
  output logic [1:0]      dmaRequest,       // card requests DMA
  output logic            merged_audio_out, // combined speaker out
  output logic [1:0]      statusChange,     // sticky change flags
  output logic            statusIrq         // change interrupt
);
  import card_socket_pkg::*;

  socket_sync_if syncBus ();

  card_input_sync card_input_sync_i (
    .mclk                (mclk),
    .rstn                (rstn),
    .battery_sense_one   (battery_sense_one),
    .battery_sense_two   (battery_sense_two),
    .card_present_one    (card_present_one),
    .card_present_two    (card_present_two),
    .io_read_acknowledge (io_read_acknowledge),
    .syncOut             (syncBus.source)
  );

  logic [1:0]   battOneS;
  logic [1:0]   battTwoS;
  logic [1:0]   ackNS;
  logic [1:0]   battOneD;
  logic [1:0]   battTwoD;
  logic [1:0]   memMode;
  logic [1:0]   audioBit;
  logic [1:0]   senseEdge;
  cycle_state_t state;
  cycle_kind_t  kind;
  logic         sock;
  logic [1:0]   lanes;
  logic [CNT_W-1:0] count;

  assign battOneS = syncBus.battSenseOne;
  assign battTwoS = syncBus.battSenseTwo;
  assign ackNS    = syncBus.readAckN;
  assign memMode  = ~ioMode;
  // audio only when configured for I/O and the pin is not a DMA request
  assign audioBit = battTwoS & ioMode & ~dmaMode;
  assign senseEdge = ((battOneS ^ battOneD) | (battTwoS ^ battTwoD))
                     & memMode;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      battStateA <= BATT_GOOD;
      battStateB <= BATT_GOOD;
    end else begin
      battStateA <= decodeBattery(battOneS[0], battTwoS[0]);
      battStateB <= decodeBattery(battOneS[1], battTwoS[1]);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cardInserted <= 2'h0;
    end else begin
      cardInserted <= ~syncBus.presentOne & ~syncBus.presentTwo;
    end
  end

  // xor merge: either card toggling is still heard with the other silent
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      merged_audio_out <= 1'b0;
    end else begin
      merged_audio_out <= audioBit[0] ^ audioBit[1];
    end
  end

  // sense two or read acknowledge from the card, either one low, gated by dmaMode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dmaRequest <= 2'h0;
    end else begin
      dmaRequest <= dmaMode & ~(battTwoS & ackNS);
    end
  end

  // a change in the same cycle as its clear is kept
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      battOneD     <= {2{SYNC_RESET}};
      battTwoD     <= {2{SYNC_RESET}};
      statusChange <= 2'h0;
      statusIrq    <= 1'b0;
    end else begin
      battOneD     <= battOneS;
      battTwoD     <= battTwoS;
      statusChange <= senseEdge | (statusChange & ~statusChangeClr);
      statusIrq    <= |(statusChange & statusChangeEn);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state   <= ST_IDLE;
      kind    <= KIND_IO_READ;
      sock    <= 1'b0;
      lanes   <= 2'h0;
      count   <= '0;
      reqBusy <= 1'b0;
      reqDone <= 1'b0;
    end else begin
      reqDone <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (reqValid) begin
            kind    <= reqKind;
            sock    <= reqSocket;
            lanes   <= reqLanes;
            count   <= loadCount(SETUP_CYCLES);
            reqBusy <= 1'b1;
            state   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (count == '0) begin
            count <= loadCount(STROBE_CYCLES);
            state <= ST_STROBE;
          end else begin
            count <= count - 1'b1;
          end
        end
        ST_STROBE: begin
          if (count == '0) begin
            count <= loadCount(HOLD_CYCLES);
            state <= ST_HOLD;
          end else begin
            count <= count - 1'b1;
          end
        end
        ST_HOLD: begin
          if (count == '0) begin
            reqBusy <= 1'b0;
            reqDone <= 1'b1;
            state   <= ST_IDLE;
          end else begin
            count <= count - 1'b1;
          end
        end
        default: begin
          state   <= ST_IDLE;
          reqBusy <= 1'b0;
        end
      endcase
    end
  end

  // the ack is sampled at the last strobe cycle, when data is settled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readAckSeen <= 1'b0;
    end else if (state == ST_STROBE && count == '0 &&
                 kind == KIND_IO_READ) begin
      readAckSeen <= ~ackNS[sock];
    end
  end

  // strobe drive follows the next state so strobes change with the state; selects and dack start one cycle after SETUP
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      even_byte_select_n <= 2'h3;
      odd_byte_select_n  <= 2'h3;
      io_read_strobe_n   <= 2'h3;
      io_write_strobe_n  <= 2'h3;
      dma_acknowledge_n  <= 2'h3;
    end else begin
      even_byte_select_n <= 2'h3;
      odd_byte_select_n  <= 2'h3;
      io_read_strobe_n   <= 2'h3;
      io_write_strobe_n  <= 2'h3;
      dma_acknowledge_n  <= 2'h3;
      if (reqBusy && !(state == ST_HOLD && count == '0)) begin
        even_byte_select_n[sock] <= ~lanes[0];
        odd_byte_select_n[sock]  <= ~lanes[1];
        dma_acknowledge_n[sock]  <= ~kind[1];
        if ((state == ST_SETUP && count == '0) ||
            (state == ST_STROBE && count != '0)) begin
          io_read_strobe_n[sock]  <= kind[0];
          io_write_strobe_n[sock] <= ~kind[0];
        end
      end
    end
  end

  property p_battLost;
    @(posedge mclk) disable iff (!rstn)
      !battOneS[0] |=> battStateA == BATT_LOST;
  endproperty
  a_battLost: assert property (p_battLost)
    else $error("battery lost not decoded");

  property p_battWeak;
    @(posedge mclk) disable iff (!rstn)
      battOneS[1] && !battTwoS[1] |=> battStateB == BATT_WEAK;
  endproperty
  a_battWeak: assert property (p_battWeak)
    else $error("battery weak not decoded");

  property p_audioMem;
    @(posedge mclk) disable iff (!rstn)
      (ioMode == 2'h0) |=> !merged_audio_out;
  endproperty
  a_audioMem: assert property (p_audioMem)
    else $error("audio heard in memory mode");

  property p_audioMerge;
    @(posedge mclk) disable iff (!rstn)
      1'b1 |=> merged_audio_out == $past(audioBit[0] ^ audioBit[1]);
  endproperty
  a_audioMerge: assert property (p_audioMerge)
    else $error("audio merge wrong");

  property p_present;
    @(posedge mclk) disable iff (!rstn)
      $fell(card_present_one[0]) && card_present_two[0] == 1'b0
      ##1 card_present_one[0] == 1'b0 && card_present_two[0] == 1'b0
      |=> ##1 cardInserted[0];
  endproperty
  a_present: assert property (p_present)
    else $error("insertion not seen");

  property p_strobeLen;
    @(posedge mclk) disable iff (!rstn)
      // five is STROBE_CYCLES; a repeat count has to be a literal
      $fell(io_read_strobe_n[0]) |->
        !io_read_strobe_n[0] [*5] ##1 io_read_strobe_n[0];
  endproperty
  a_strobeLen: assert property (p_strobeLen)
    else $error("read strobe width wrong");

  property p_noBothStrobes;
    @(posedge mclk) disable iff (!rstn)
      !(io_read_strobe_n[sock] == 1'b0 && io_write_strobe_n[sock] == 1'b0);
  endproperty
  a_noBothStrobes: assert property (p_noBothStrobes)
    else $error("both strobes low");

  property p_dackDma;
    @(posedge mclk) disable iff (!rstn)
      (io_write_strobe_n != 2'h3) && kind == KIND_DMA_TO_CARD
      |-> dma_acknowledge_n == io_write_strobe_n;
  endproperty
  a_dackDma: assert property (p_dackDma)
    else $error("dma acknowledge missing");

  property p_selectDuring;
    @(posedge mclk) disable iff (!rstn)
      (io_read_strobe_n != 2'h3) |->
        (even_byte_select_n & odd_byte_select_n) != 2'h3;
  endproperty
  a_selectDuring: assert property (p_selectDuring)
    else $error("strobe without byte enable");

  property p_flagKeep;
    @(posedge mclk) disable iff (!rstn)
      senseEdge[0] |=> statusChange[0] ##1 statusIrq == statusChangeEn[0]
        || statusChange[1];
  endproperty
  a_flagKeep: assert property (p_flagKeep)
    else $error("status change lost");
endmodule

// [include/card_socket_pkg.sv]
// shared constants, types and helpers for the card socket control block
package card_socket_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SETUP_TIME_NS  = 80;
  localparam int STROBE_TIME_NS = 200;
  localparam int HOLD_TIME_NS   = 40;
  // least times, rounded up to whole cycles
  localparam int SETUP_CYCLES  = (SETUP_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES   = (HOLD_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam int NUM_SOCKETS   = 2;
  // card pins idle high through pull-ups
  localparam logic SYNC_RESET  = 1'b1;

  typedef enum logic [1:0] {
    BATT_GOOD = 2'h0,
    BATT_WEAK = 2'h1,
    BATT_LOST = 2'h2
  } batt_state_t;

  typedef enum logic [1:0] {
    KIND_IO_READ       = 2'h0,
    KIND_IO_WRITE      = 2'h1,
    KIND_DMA_FROM_CARD = 2'h2,
    KIND_DMA_TO_CARD   = 2'h3
  } cycle_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } cycle_state_t;

  function automatic batt_state_t decodeBattery(input logic senseOne,
                                                input logic senseTwo);
    if (!senseOne) begin
      return BATT_LOST;
    end else if (!senseTwo) begin
      return BATT_WEAK;
    end
    return BATT_GOOD;
  endfunction

  function automatic logic [CNT_W-1:0] loadCount(input int cycles);
    return CNT_W'(cycles - 1);
  endfunction
endpackage

// [include/socket_sync_if.sv]
// synchronised card-driven inputs of both sockets
`timescale 1ns/1ps
interface socket_sync_if;
  logic [1:0] battSenseOne;
  logic [1:0] battSenseTwo;
  logic [1:0] presentOne;
  logic [1:0] presentTwo;
  logic [1:0] readAckN;
  modport source (output battSenseOne, battSenseTwo, presentOne,
                  presentTwo, readAckN);
  modport sink   (input battSenseOne, battSenseTwo, presentOne,
                  presentTwo, readAckN);
endinterface

// [design/card_input_sync.sv]
// two-flop synchronisers for the card-driven socket inputs
`timescale 1ns/1ps
module card_input_sync (
  input  wire logic       mclk,             // core clock
  input  wire logic       rstn,             // async reset, active low
  input  wire logic [1:0] battery_sense_one, // raw sense one per socket
  input  wire logic [1:0] battery_sense_two, // raw sense two per socket
  input  wire logic [1:0] card_present_one, // raw detect one, low=in
  input  wire logic [1:0] card_present_two, // raw detect two, low=in
  input  wire logic [1:0] io_read_acknowledge, // raw ack, low active
  socket_sync_if.source   syncOut           // synchronised copies
);
  import card_socket_pkg::*;

  logic [9:0] stageOne;
  logic [9:0] stageTwo;

  // first stage is read only by the second stage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stageOne <= {10{SYNC_RESET}};
      stageTwo <= {10{SYNC_RESET}};
    end else begin
      stageOne <= {io_read_acknowledge, card_present_two,
                   card_present_one, battery_sense_two, battery_sense_one};
      stageTwo <= stageOne;
    end
  end

  assign syncOut.battSenseOne = stageTwo[1:0];
  assign syncOut.battSenseTwo = stageTwo[3:2];
  assign syncOut.presentOne   = stageTwo[5:4];
  assign syncOut.presentTwo   = stageTwo[7:6];
  assign syncOut.readAckN     = stageTwo[9:8];
endmodule

// [tb/card_model.sv]
// behavioural model of the cards in both sockets
`timescale 1ns/1ps
module card_model (
  input  wire logic [1:0] ioReadStrobeN, // read strobe from controller
  input  wire logic [1:0] present,       // card sits in the socket
  input  wire logic [1:0] battOne,       // battery level one
  input  wire logic [1:0] battTwo,       // battery level two
  input  wire logic [1:0] ackOk,         // card answers io reads
  input  wire logic [1:0] dmaReq,        // card wants dma to it
  input  wire logic [1:0] ackReq,        // card strobes ack for dma
  output logic [1:0]      senseOne,      // sense pin one
  output logic [1:0]      senseTwo,      // sense pin two
  output logic [1:0]      detectOne,     // detect pin one
  output logic [1:0]      detectTwo,     // detect pin two
  output logic [1:0]      readAckN       // ack pin, low active
);
  // an empty socket leaves every card pin on its pull-up
  assign senseOne  = ~present | battOne;
  assign senseTwo  = ~present | (battTwo & ~dmaReq);
  assign detectOne = ~present;
  assign detectTwo = ~present;
  assign readAckN  = ~(present & ((ackOk & ~ioReadStrobeN) | ackReq));
endmodule

// [tb/card_socket_control_bench.sv]
// self-checking bench for the card socket control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module card_socket_control_bench;
  import card_socket_pkg::*;
  logic mclk = 0, rstn = 0, reqValid = 0, reqSocket = 0;
  logic [1:0] ioMode = 0, dmaMode = 0, statusChangeEn = 0;
  logic [1:0] statusChangeClr = 0, reqLanes = 0;
  cycle_kind_t reqKind = KIND_IO_READ;
  logic [1:0] present = 3, battOne = 3, battTwo = 3, ackOk = 0;
  logic [1:0] dmaReq = 0, ackReq = 0;
  logic [1:0] sOne, sTwo, dOne, dTwo, ackN, evenN, oddN, rdN, wrN, dackN;
  logic [1:0] cardInserted, dmaRequest, statusChange;
  logic reqBusy, reqDone, readAckSeen, merged, statusIrq;
  batt_state_t battStateA, battStateB;
  int error_cnt = 0, total_checks = 0;

  always #20 mclk = ~mclk;

  card_model card_model_i (.ioReadStrobeN(rdN), .present(present),
    .battOne(battOne), .battTwo(battTwo), .ackOk(ackOk), .dmaReq(dmaReq),
    .ackReq(ackReq), .senseOne(sOne), .senseTwo(sTwo), .detectOne(dOne),
    .detectTwo(dTwo), .readAckN(ackN));

  card_socket_control card_socket_control_i (.mclk(mclk), .rstn(rstn),
    .battery_sense_one(sOne), .battery_sense_two(sTwo),
    .card_present_one(dOne), .card_present_two(dTwo),
    .io_read_acknowledge(ackN), .ioMode(ioMode), .dmaMode(dmaMode),
    .statusChangeEn(statusChangeEn), .statusChangeClr(statusChangeClr),
    .reqValid(reqValid), .reqKind(reqKind), .reqSocket(reqSocket),
    .reqLanes(reqLanes), .reqBusy(reqBusy), .reqDone(reqDone),
    .readAckSeen(readAckSeen), .even_byte_select_n(evenN),
    .odd_byte_select_n(oddN), .io_read_strobe_n(rdN),
    .io_write_strobe_n(wrN), .dma_acknowledge_n(dackN),
    .battStateA(battStateA), .battStateB(battStateB),
    .cardInserted(cardInserted), .dmaRequest(dmaRequest),
    .merged_audio_out(merged), .statusChange(statusChange),
    .statusIrq(statusIrq));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // inputs pass two sync flops and an output flop, so settle generously
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic t_battery();
    logic [1:0] one;
    batt_state_t tbl[4];
    tbl = '{BATT_GOOD, BATT_WEAK, BATT_LOST, BATT_LOST};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      battOne <= {i[1] ^ i[0], ~i[1]} ;
      battTwo <= {~i[0], ~i[0]};
      settle(5);
      one = {i[1] ^ i[0], ~i[1]};
      `CHK("battStateA", tbl[i], battStateA)
      `CHK("battStateB", (one[1] ? (i[0] ? BATT_WEAK : BATT_GOOD) : BATT_LOST), battStateB)
    end
  endtask

  task automatic t_status();
    @(posedge mclk);
    battOne <= 3;
    battTwo <= 3;
    statusChangeEn <= 0;
    settle(5);
    statusChangeClr <= 3;
    settle(1);
    statusChangeClr <= 0;
    settle(3);
    `CHK("statusChange", 2'h0, statusChange)
    battOne <= 2'h2 ^ battOne;
    settle(6);
    `CHK("statusChange", 2'h2, statusChange)
    `CHK("statusIrq", 1'b0, statusIrq)
    statusChangeEn <= 2'h2;
    settle(3);
    `CHK("statusIrq", 1'b1, statusIrq)
    statusChangeClr <= 2'h2;
    settle(1);
    statusChangeClr <= 0;
    settle(3);
    `CHK("statusIrq", 1'b0, statusIrq)
  endtask

  task automatic t_detect();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      present <= 2'(i);
      settle(5);
      `CHK("cardInserted", 2'(i), cardInserted)
    end
  endtask

  task automatic t_audio();
    @(posedge mclk);
    ioMode <= 3;
    battOne <= 3;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      battTwo <= 2'(i);
      settle(5);
      `CHK("merged", i[0] ^ i[1], merged)
    end
    // a toggling pin must stay silent once the socket is in memory mode
    ioMode <= 0;
    battTwo <= 2'h1;
    settle(5);
    `CHK("merged", 1'b0, merged)
    battTwo <= 3;
  endtask

  task automatic t_dma_req();
    @(posedge mclk);
    dmaMode <= 3;
    dmaReq <= 2'h1;
    settle(5);
    `CHK("dmaRequest", 2'h1, dmaRequest)
    dmaReq <= 0;
    ackReq <= 2'h2;
    settle(5);
    `CHK("dmaRequest", 2'h2, dmaRequest)
    // request pin still active: only the mode may hide it
    dmaMode <= 0;
    settle(5);
    `CHK("dmaRequest", 2'h0, dmaRequest)
    ackReq <= 0;
  endtask

  task automatic run_cycle(input cycle_kind_t k, input logic s,
                           input logic [1:0] ln);
    int lowCnt, firstLow;
    logic rd;
    logic [1:0] st, other;
    rd = (k == KIND_IO_READ) || (k == KIND_DMA_FROM_CARD);
    lowCnt = 0;
    firstLow = 0;
    @(posedge mclk);
    reqValid <= 1;
    reqKind <= k;
    reqSocket <= s;
    reqLanes <= ln;
    @(posedge mclk);
    reqValid <= 0;
    for (int i = 1; i <= 9; i++) begin
      @(posedge mclk);
      #1;
      st = rd ? rdN : wrN;
      other = rd ? wrN : rdN;
      if (st[s] === 1'b0) begin
        lowCnt++;
        if (firstLow == 0) firstLow = i;
      end
      `CHK("otherStrobe", 1'b1, other[s])
      if (i == 1) begin
        `CHK("reqBusy", 1'b1, reqBusy)
        `CHK("evenSel", ~ln[0], evenN[s])
        `CHK("oddSel", ~ln[1], oddN[s])
        `CHK("dma_acknowledge", ~k[1], dackN[s])
      end
      // samples land just after the edge that launched them
      if (i == SETUP_CYCLES + STROBE_CYCLES + HOLD_CYCLES) begin
        `CHK("reqDone", 1'b1, reqDone)
      end
    end
    `CHK("strobeLen", STROBE_CYCLES, lowCnt)
    `CHK("strobeStart", SETUP_CYCLES, firstLow)
    `CHK("reqDone", 1'b0, reqDone)
    `CHK("reqBusy", 1'b0, reqBusy)
    `CHK("evenSel", 1'b1, evenN[s])
  endtask

  task automatic t_cycles();
    @(posedge mclk);
    present <= 3;
    ioMode <= 3;
    ackOk <= 2'h1;
    for (int k = 0; k < 4; k++) begin
      run_cycle(cycle_kind_t'(k), k[0], 2'(3 - k));
    end
    run_cycle(KIND_IO_READ, 1'b0, 2'h3);
    `CHK("readAckSeen", 1'b1, readAckSeen)
    run_cycle(KIND_IO_READ, 1'b1, 2'h3);
    `CHK("readAckSeen", 1'b0, readAckSeen)
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1;
    t_battery();
    t_status();
    t_detect();
    t_audio();
    t_dma_req();
    t_cycles();
    report_and_stop();
  end

  // all scenarios need well under 1000 cycles
  initial begin
    #(40 * 3000);
    error_cnt++;
    report_and_stop();
  end
endmodule
